// *** rtl/ssp_defines.vh ***
// constants for the subsystem-port controller (host side of the port)
// assumes: included by bare name from rtl design files
`ifndef SSP_DEFINES_VH
`define SSP_DEFINES_VH
// ************************************************************
// address map
// ************************************************************
`define SSP_ADDR_W        9
`define SSP_INFO_LAST     9'h0FF
`define SSP_CFG_FIRST     9'h100
`define SSP_CFG_LAST      9'h107
// ************************************************************
// pin encodings
// ************************************************************
`define SSP_STRAP_MUX     1'h0
`define SSP_STRAP_SEP     1'h1
`define SSP_STYLE_STROBES 1'h0
`define SSP_STYLE_DSRW    1'h1
// ************************************************************
// timing, in ns, rounded up to clk cycles at 100 MHz
// ************************************************************
`define SSP_PHASE_NS      30
`define SSP_CLK_NS        10
`define SSP_PHASE_CYC     ((`SSP_PHASE_NS + `SSP_CLK_NS - 1) / `SSP_CLK_NS)
`endif

// *** rtl/ssp_host.v ***
// controller that drives the card's subsystem attribute-memory port
// assumes: pins are synchronous to clk; bus wires resolved by the bench
`timescale 1ns/1ps
`default_nettype none
`include "ssp_defines.vh"
// Functional notes
// (R1) strap 0 means multiplexed address/data, strap 1 separate buses.
// (R2) the low address pins only carry address while the strap is high.
// (R3) the upper address pin is bit 8 of a nine-bit address in both modes.
// (R4) the shared lines carry address then data when muxed, data only else.
// (R5) style 1 is strobe plus direction, style 0 is separate read/write.
// (R6) the write pin is a write strobe in style 0, a direction in style 1.
// (R7) the card may pull the status-change line low after a local write.
// (R8) when muxed the address is latched by a positive or negative pulse.
// (R9) reads and writes are signalled by the strobe/direction pairs.
// (R10) addresses 0-255 are info memory, 256-263 configuration registers.
// (R11) the strap is static and defaults to multiplexed operation; the code reloads it from cfg_separate while idle with no request.
module ssp_host #(
  parameter PHASE_CYC = `SSP_PHASE_CYC
) (
  input  wire       clk,
  input  wire       rst_b,
  input  wire       cfg_separate,
  input  wire       cfg_style,
  input  wire       req_valid,
  output wire       req_ready,
  input  wire       req_write,
  input  wire [8:0] req_addr,
  input  wire [7:0] req_wdata,
  output reg        rsp_valid,
  output reg  [7:0] rsp_rdata,
  output reg        rsp_error,
  output reg        status_seen,
  output reg        bus_separation_strap,
  output reg        bus_style_select,
  output reg  [7:0] sub_low_addr,
  output reg        sub_addr_bit8,
  input  wire [7:0] sub_shared_addr_data_in,
  output reg  [7:0] sub_shared_addr_data_out,
  output reg        sub_shared_addr_data_oe,
  output reg        sub_addr_latch_strobe,
  output reg        sub_read_or_strobe,
  output reg        sub_write_or_dir,
  input  wire       host_status_change_n
);
  // ************************************************************
  // state machine
  // ************************************************************
  localparam [4:0] S_IDLE  = 5'h01;
  localparam [4:0] S_ALE   = 5'h02;
  localparam [4:0] S_SETUP = 5'h04;
  localparam [4:0] S_STRB  = 5'h08;
  localparam [4:0] S_HOLD  = 5'h10;

  reg  [4:0] state;
  reg  [4:0] next_state;
  reg        wr;
  // write data is kept here: the requester may move req_wdata once taken
  reg  [7:0] wdata;
  wire       tick;

  // ************************************************************
  // helpers
  // ************************************************************
  function in_map;
    input [8:0] a;
    begin
      in_map = (a <= `SSP_CFG_LAST); // [R10]
    end
  endfunction

  // inactive level of the address latch strobe: low for the positive
  // pulse of style 0, high for the negative pulse of style 1
  function latch_idle;
    input style;
    begin
      latch_idle = style; // [R8]
    end
  endfunction

  assign req_ready = (state == S_IDLE);

  // ************************************************************
  // phase divider
  // ************************************************************
  ssp_phase_tick #(
    .PHASE_CYC (PHASE_CYC)
  ) u_tick (
    .clk   (clk),
    .rst_b (rst_b),
    .run   (state != S_IDLE),
    .tick  (tick)
  );

  // ************************************************************
  // next state
  // ************************************************************
  always @* begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (req_valid && in_map(req_addr)) begin
          if (bus_separation_strap == `SSP_STRAP_MUX)
            next_state = S_ALE; // [R8]
          else
            next_state = S_SETUP;
        end
      end
      S_ALE:   if (tick) next_state = S_SETUP;
      S_SETUP: if (tick) next_state = S_STRB;
      S_STRB:  if (tick) next_state = S_HOLD;
      S_HOLD:  if (tick) next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
  end

  // ************************************************************
  // pin drive
  // ************************************************************
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state                    <= S_IDLE;
      wr                       <= 1'b0;
      wdata                    <= 8'h00;
      rsp_valid                <= 1'b0;
      rsp_rdata                <= 8'h00;
      rsp_error                <= 1'b0;
      status_seen              <= 1'b0;
      bus_separation_strap     <= `SSP_STRAP_MUX; // [R11]
      bus_style_select         <= `SSP_STYLE_STROBES;
      sub_low_addr             <= 8'h00;
      sub_addr_bit8            <= 1'b0;
      sub_shared_addr_data_out <= 8'h00;
      sub_shared_addr_data_oe  <= 1'b0;
      sub_addr_latch_strobe    <= 1'b0;
      sub_read_or_strobe       <= 1'b1;
      sub_write_or_dir         <= 1'b1;
    end else begin
      state     <= next_state;
      rsp_valid <= 1'b0;
      rsp_error <= 1'b0;
      // set wins over the clear done by a new request
      if (!host_status_change_n)
        status_seen <= 1'b1; // [R7]
      else if (req_valid && req_ready)
        status_seen <= 1'b0;
      case (state)
        S_IDLE: begin
          // strap and style move only while no request stands, so the
          // access taken at this edge runs wholly in the mode it was
          // checked against
          if (!req_valid) begin
            bus_separation_strap  <= cfg_separate; // [R1] [R11]
            bus_style_select      <= cfg_style; // [R5]
            sub_addr_latch_strobe <= latch_idle(cfg_style); // [R8]
            // a stale low address must not stay on the unused pins
            if (cfg_separate == `SSP_STRAP_MUX)
              sub_low_addr <= 8'h00; // [R2]
          end
          if (req_valid && !in_map(req_addr)) begin
            rsp_valid <= 1'b1;
            rsp_error <= 1'b1;
          end else if (req_valid) begin
            wr            <= req_write;
            wdata         <= req_wdata;
            sub_addr_bit8 <= req_addr[8]; // [R3]
            if (bus_separation_strap == `SSP_STRAP_SEP) begin
              sub_low_addr             <= req_addr[7:0]; // [R2]
              sub_shared_addr_data_out <= req_wdata; // [R4]
              sub_shared_addr_data_oe  <= req_write;
            end else begin
              sub_low_addr             <= 8'h00; // [R2]
              sub_shared_addr_data_out <= req_addr[7:0]; // [R4]
              sub_shared_addr_data_oe  <= 1'b1;
              // positive pulse style 0, negative pulse style 1
              sub_addr_latch_strobe <= ~latch_idle(bus_style_select); // [R8]
            end
            if (bus_style_select == `SSP_STYLE_DSRW)
              sub_write_or_dir <= ~req_write; // [R6]
          end
        end
        S_ALE: begin
          if (tick) begin
            sub_addr_latch_strobe    <= latch_idle(bus_style_select); // [R8]
            sub_shared_addr_data_out <= wdata; // [R4]
            sub_shared_addr_data_oe  <= wr; // [R4]
          end
        end
        S_SETUP: begin
          if (tick) begin
            if (bus_style_select == `SSP_STYLE_DSRW) begin
              sub_read_or_strobe <= 1'b0; // [R9]
            end else if (wr) begin
              sub_write_or_dir <= 1'b0; // [R6] [R9]
            end else begin
              sub_read_or_strobe <= 1'b0; // [R9]
            end
          end
        end
        S_STRB: begin
          if (tick) begin
            sub_read_or_strobe <= 1'b1;
            if (bus_style_select == `SSP_STYLE_STROBES)
              sub_write_or_dir <= 1'b1;
            if (!wr)
              rsp_rdata <= sub_shared_addr_data_in;
          end
        end
        S_HOLD: begin
          if (tick) begin
            sub_shared_addr_data_oe <= 1'b0;
            sub_write_or_dir        <= 1'b1;
            sub_addr_latch_strobe   <= latch_idle(bus_style_select);
            rsp_valid               <= 1'b1;
          end
        end
        default: begin
          sub_shared_addr_data_oe <= 1'b0;
        end
      endcase
    end
  end
endmodule // ssp_host
`default_nettype wire

// *** rtl/ssp_phase_tick.v ***
// phase divider: one-cycle enable pulse every PHASE_CYC clocks while run
// assumes: single clock, async active-low reset
`timescale 1ns/1ps
`default_nettype none
module ssp_phase_tick #(
  parameter PHASE_CYC = 3
) (
  input  wire clk,
  input  wire rst_b,
  input  wire run,
  output reg  tick
);
  reg [7:0] count;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= 8'h00;
      tick  <= 1'b0;
    end else if (!run) begin
      count <= 8'h00;
      tick  <= 1'b0;
    end else if (count == PHASE_CYC[7:0] - 8'h01) begin
      count <= 8'h00;
      tick  <= 1'b1;
    end else begin
      count <= count + 8'h01;
      tick  <= 1'b0;
    end
  end
endmodule // ssp_phase_tick
`default_nettype wire

// *** testbench/ssp_dev_model.sv ***
// device model: attribute memory behind the subsystem port
// assumes: driven by the ssp_host pins, behavioural timing
`timescale 1ns/1ps
`default_nettype none
module ssp_dev_model (
  input  wire logic       strap,
  input  wire logic       style,
  input  wire logic [7:0] lo,
  input  wire logic       a8,
  input  wire logic [7:0] dout,
  input  wire logic       oe,
  input  wire logic       ale,
  input  wire logic       rd_n,
  input  wire logic       wr,
  output wire logic [7:0] din,
  output var  logic       stat_n
);
  logic [7:0] mem [0:263];
  logic [8:0] la;
  integer     i;
  // read decode is the same expression in both styles
  wire rd_on = !rd_n && wr;
  wire wr_on = style ? (!rd_n && !wr) : !wr;
  initial begin
    stat_n = 1'b1;
    la = 9'h000;
    for (i = 0; i < 264; i = i + 1) mem[i] = i[7:0] ^ 8'hA5;
  end
  // undriven strap reads as muxed
  always @* begin
    if (strap === 1'b1) la = {a8, lo};
    else if (ale !== style) la = {a8, dout};
  end
  // released lines show the inverse of the host's last drive
  assign din = oe ? dout : (rd_on ? mem[la] : ~dout);
  always @(negedge wr_on) begin
    if (oe && la <= 9'h107) mem[la] <= dout;
    stat_n <= 1'b0;
    #20 stat_n <= 1'b1;
  end
endmodule // ssp_dev_model
`default_nettype wire

// *** testbench/ssp_host_asserts.sv ***
// checker on the subsystem pins of ssp_host
// assumes: bound to ssp_host, one clock domain
`timescale 1ns/1ps
`default_nettype none
module ssp_host_asserts (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       req_valid,
  input wire logic       req_ready,
  input wire logic [8:0] req_addr,
  input wire logic       rsp_valid,
  input wire logic       rsp_error,
  input wire logic       bus_separation_strap,
  input wire logic       bus_style_select,
  input wire logic [7:0] sub_low_addr,
  input wire logic       sub_addr_latch_strobe,
  input wire logic       sub_read_or_strobe,
  input wire logic       sub_write_or_dir
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_taken; req_valid && req_ready; endsequence
  sequence s_strb; bus_style_select && !sub_read_or_strobe; endsequence
  property p_mux_lo; !bus_separation_strap |-> sub_low_addr == 8'h00;
  endproperty
  a_mux_lo: assert property (p_mux_lo) else $error("low addr in mux");
  property p_err; s_taken ##0 req_addr > 9'h107 |=> rsp_valid && rsp_error;
  endproperty
  a_err: assert property (p_err) else $error("no error answer");
  property p_excl; !bus_style_select |-> sub_read_or_strobe || sub_write_or_dir;
  endproperty
  a_excl: assert property (p_excl) else $error("both strobes low");
  property p_dir; s_strb |-> $stable(sub_write_or_dir); endproperty
  a_dir: assert property (p_dir) else $error("direction moved");
  property p_ale_off; !bus_separation_strap && (!sub_read_or_strobe ||
    (!bus_style_select && !sub_write_or_dir)) |->
    sub_addr_latch_strobe == bus_style_select; endproperty
  a_ale_off: assert property (p_ale_off) else $error("latch on");
  property p_ale_on; s_taken ##0 (!bus_separation_strap &&
    req_addr <= 9'h107) |=> sub_addr_latch_strobe != bus_style_select;
  endproperty
  a_ale_on: assert property (p_ale_on) else $error("no latch");
  property p_cfg; !$stable(bus_style_select) ||
    !$stable(bus_separation_strap) |-> $past(req_ready); endproperty
  a_cfg: assert property (p_cfg) else $error("mode change busy");
endmodule // ssp_host_asserts
`default_nettype wire

// *** testbench/subsystem_port_decode_test.sv ***
// top bench: ssp_host against the device model
// assumes: 100 MHz clock, design default phase length
`timescale 1ns/1ps
`default_nettype none
module subsystem_port_decode_test;
  logic clk, rst_b, cfg_separate, cfg_style, req_valid, req_write;
  logic req_ready, rsp_valid, rsp_error, status_seen, bus_separation_strap;
  logic bus_style_select, sub_addr_bit8, sub_shared_addr_data_oe;
  logic sub_addr_latch_strobe, sub_read_or_strobe, sub_write_or_dir;
  logic host_status_change_n;
  logic [8:0] req_addr, a;
  logic [7:0] req_wdata, rsp_rdata, sub_low_addr, sub_shared_addr_data_in;
  logic [7:0] sub_shared_addr_data_out;
  integer fail_count = 0, num_checks = 0, cyc = 0;
  ssp_host dut_u (.clk, .rst_b, .cfg_separate, .cfg_style, .req_valid,
    .req_ready, .req_write, .req_addr, .req_wdata, .rsp_valid, .rsp_rdata,
    .rsp_error, .status_seen, .bus_separation_strap, .bus_style_select,
    .sub_low_addr, .sub_addr_bit8, .sub_shared_addr_data_in,
    .sub_shared_addr_data_out, .sub_shared_addr_data_oe,
    .sub_addr_latch_strobe, .sub_read_or_strobe, .sub_write_or_dir,
    .host_status_change_n);
  ssp_dev_model dev_u (.strap(bus_separation_strap), .style(bus_style_select),
    .lo(sub_low_addr), .a8(sub_addr_bit8), .dout(sub_shared_addr_data_out),
    .oe(sub_shared_addr_data_oe), .ale(sub_addr_latch_strobe),
    .rd_n(sub_read_or_strobe), .wr(sub_write_or_dir),
    .din(sub_shared_addr_data_in), .stat_n(host_status_change_n));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task close_out;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks = num_checks + 1;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      fail_count = fail_count + 1;
    end
  endtask
  // request held for exactly the one edge that takes it
  task xfer(input logic w, input logic [8:0] ad, input logic [7:0] d);
    integer n;
    @(negedge clk);
    req_valid = 1'b1;
    req_write = w;
    req_addr = ad;
    req_wdata = d;
    @(negedge clk);
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 60) begin
      @(posedge clk);
      #1;
      n = n + 1;
    end
    chk("rsp_valid", 8'h01, {7'h00, rsp_valid});
  endtask
  task sc_modes;
    integer m;
    for (m = 0; m < 4; m = m + 1) begin
      @(negedge clk);
      cfg_separate = m[1];
      cfg_style = m[0];
      repeat (2) @(negedge clk);
      chk("pins", m[1:0], {bus_separation_strap, bus_style_select});
      chk("latch idle", m[0], sub_addr_latch_strobe);
      a = m[0] ? 9'h107 - m : 9'h0FF - m;
      xfer(1'b1, a, 8'h5A + m);
      chk("status", 8'h01, {7'h00, status_seen});
      xfer(1'b0, a, 8'h00);
      chk("rdata", 8'h5A + m, rsp_rdata);
      chk("status clr", 8'h00, {7'h00, status_seen});
      if (m[0]) begin
        xfer(1'b0, a ^ 9'h100, 8'h00);
        chk("bit8", a[7:0] ^ 8'hA5, rsp_rdata);
      end
    end
  endtask
  task sc_err;
    xfer(1'b1, 9'h108, 8'h11);
    chk("err", 8'h01, {7'h00, rsp_error});
  endtask
  // back from separate buses to muxed: stale low address and latch level
  task sc_back;
    @(negedge clk);
    cfg_separate = 1'b0;
    cfg_style = 1'b0;
    repeat (2) @(negedge clk);
    chk("low addr", 8'h00, sub_low_addr);
    chk("latch back", 8'h00, {7'h00, sub_addr_latch_strobe});
    xfer(1'b0, 9'h0FF, 8'h00);
    chk("mux again", 8'h5A, rsp_rdata);
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      fail_count = fail_count + 1;
      close_out;
    end
  end
  initial begin
    rst_b = 1'b0;
    {cfg_separate, cfg_style, req_valid, req_write} = 4'h0;
    req_addr = 9'h000;
    req_wdata = 8'h00;
    repeat (8) @(negedge clk);
    chk("idle", 8'h01, {7'h00, sub_read_or_strobe});
    rst_b = 1'b1;
    sc_modes;
    sc_err;
    sc_back;
    close_out;
  end
endmodule // subsystem_port_decode_test
bind ssp_host ssp_host_asserts chk_u (.clk, .rst_b, .req_valid, .req_ready,
  .req_addr, .rsp_valid, .rsp_error, .bus_separation_strap,
  .bus_style_select, .sub_low_addr, .sub_addr_latch_strobe,
  .sub_read_or_strobe, .sub_write_or_dir);
`default_nettype wire
